// ==== logic/dsad_decode.sv ====
// Data-space decoder with on-chip RAM and flash-configuration load
`timescale 1ns/100ps
`default_nettype none

module dsad_decode (
   input  wire logic               i_sys_clk,
   input  wire logic               i_rst,
   input  wire logic               i_external_data_select,
   input  wire dsad_pkg::dsad_req_t i_req,
   output logic                    o_ready,
   output logic [31:0]             o_rdata,
   output logic                    o_rvalid,
   output dsad_pkg::dsad_tgt_t     o_dflash,
   output dsad_pkg::dsad_tgt_t     o_periph,
   output dsad_pkg::dsad_tgt_t     o_debug,
   output dsad_pkg::dsad_tgt_t     o_ext,
   input  wire logic [31:0]        i_dflash_rdata,
   input  wire logic [31:0]        i_periph_rdata,
   input  wire logic [31:0]        i_debug_rdata,
   input  wire logic [31:0]        i_ext_rdata,
   output logic                    o_pflash_rd,
   output logic [23:0]             o_pflash_addr,
   input  wire logic [15:0]        i_pflash_rdata,
   output logic                    o_cfg_we,
   output logic [3:0]              o_cfg_idx,
   output logic [15:0]             o_cfg_data,
   output logic                    o_init_done
);
   import dsad_pkg::*;

   typedef enum {ST_ISSUE, ST_CAPTURE, ST_DONE} dsad_init_t;

   dsad_init_t         init_q;
   logic [3:0]         cfg_idx_q;
   logic [3:0]         cfg_idx_d;
   logic               cfg_we_q;
   logic [15:0]        cfg_data_q;
   logic               pflash_rd_q;
   logic               mode_q;
   dsad_region_t       region;
   dsad_region_t       region_q;
   logic               ram_hit;
   logic               take;
   logic [31:0]        ram_q [RAM_DEPTH];
   logic [31:0]        ram_rdata_q;
   logic               rvalid_q;
   logic [31:0]        ext_rdata_q;

   // ----------------------------------------------------------------
   // Configuration load from top of program flash
   // ----------------------------------------------------------------
   // Flash is nonvolatile, so the load repeats after every reset
   assign cfg_idx_d = cfg_idx_q + 4'h1;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         init_q      <= ST_ISSUE;
         cfg_idx_q   <= 4'h0;
         cfg_we_q    <= 1'b0;
         cfg_data_q  <= 16'h0000;
         pflash_rd_q <= 1'b0;
      end else begin
         cfg_we_q <= 1'b0;
         case (init_q)
            ST_ISSUE: begin
               // Strobe rises next cycle and flash answers within that cycle, so capture follows directly
               pflash_rd_q <= 1'b1;
               init_q      <= ST_CAPTURE;
            end
            ST_CAPTURE: begin
               pflash_rd_q <= 1'b0;
               cfg_we_q    <= 1'b1;
               cfg_data_q  <= i_pflash_rdata;
               if (cfg_idx_q == CFG_LAST_IDX) begin
                  init_q <= ST_DONE;
               end else begin
                  init_q <= ST_ISSUE;
               end
            end
            default: begin
               pflash_rd_q <= 1'b0;
            end
         endcase
         if (init_q == ST_CAPTURE && cfg_idx_q != CFG_LAST_IDX) begin
            cfg_idx_q <= cfg_idx_d;
         end
      end
   end

   // Write index lags the fetch index by one; the written slot is the one just read
   logic [3:0] cfg_wr_idx_q;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         cfg_wr_idx_q <= 4'h0;
      end else if (init_q == ST_CAPTURE) begin
         cfg_wr_idx_q <= cfg_idx_q;
      end
   end

   assign o_pflash_rd   = pflash_rd_q;
   assign o_pflash_addr = CFG_FIRST + {20'h00000, cfg_idx_q};
   // One write port: all nine configuration words share one control set
   assign o_cfg_we      = cfg_we_q;
   assign o_cfg_idx     = cfg_wr_idx_q;
   assign o_cfg_data    = cfg_data_q;
   assign o_init_done   = (init_q == ST_DONE) && !cfg_we_q;

   // ----------------------------------------------------------------
   // Mode bit sampled; it arrives from another block on this clock
   // ----------------------------------------------------------------
   // One cycle of lag: a mode change reaches the request in the cycle after it
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         mode_q <= 1'b0;
      end else begin
         mode_q <= i_external_data_select;
      end
   end

   // ----------------------------------------------------------------
   // Region decode on word addresses
   // ----------------------------------------------------------------
   always_comb begin
      // Fixed windows first; they ignore the mode bit
      // Address compared as-is: each unit is one 16-bit word
      if (i_req.addr >= PERIPH_LO && i_req.addr <= PERIPH_HI) begin
         region = DSAD_RGN_PERIPH;
      end else if (i_req.addr >= DEBUG_LO) begin
         region = DSAD_RGN_DEBUG;
      end else if (!mode_q && i_req.addr <= RAM_HI) begin
         region = DSAD_RGN_RAM;
      end else if (!mode_q && i_req.addr >= DFLASH_LO && i_req.addr <= DFLASH_HI) begin
         region = DSAD_RGN_DFLASH;
      end else begin
         region = DSAD_RGN_EXT;
      end
   end

   // Core held off until the flash controls are loaded
   assign o_ready = o_init_done;
   assign take    = i_req.valid && o_init_done;
   assign ram_hit = take && region == DSAD_RGN_RAM;

   always_comb begin
      o_dflash         = '{sel: 1'b0, write: i_req.write, long_op: i_req.long_op,
                           addr: i_req.addr, wdata: i_req.wdata};
      o_periph         = o_dflash;
      o_debug          = o_dflash;
      o_ext            = o_dflash;
      // Data flash has its own control set, separate from program side
      o_dflash.sel     = take && region == DSAD_RGN_DFLASH;
      o_periph.sel     = take && region == DSAD_RGN_PERIPH;
      o_debug.sel      = take && region == DSAD_RGN_DEBUG;
      o_ext.sel        = take && region == DSAD_RGN_EXT;
   end

   // ----------------------------------------------------------------
   // On-chip data RAM, 2K x 32 for single-cycle long words
   // ----------------------------------------------------------------
   // Word address bit 0 picks the half; a long op moves both at once
   logic [RAM_AW-1:0] ram_row;
   assign ram_row = i_req.addr[RAM_AW:1];

   always_ff @(posedge i_sys_clk) begin
      if (ram_hit && i_req.write) begin
         if (i_req.long_op) begin
            ram_q[ram_row] <= i_req.wdata;
         end else if (i_req.addr[0]) begin
            ram_q[ram_row][31:16] <= i_req.wdata[15:0];
         end else begin
            ram_q[ram_row][15:0] <= i_req.wdata[15:0];
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (ram_hit && !i_req.write) begin
         if (i_req.long_op || !i_req.addr[0]) begin
            ram_rdata_q <= ram_q[ram_row];
         end else begin
            ram_rdata_q <= {16'h0000, ram_q[ram_row][31:16]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Read return, one cycle after a read is taken
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rvalid_q    <= 1'b0;
         region_q    <= DSAD_RGN_EXT;
         ext_rdata_q <= 32'h00000000;
      end else begin
         rvalid_q <= take && !i_req.write;
         region_q <= region;
         case (region)
            DSAD_RGN_DFLASH: ext_rdata_q <= i_dflash_rdata;
            DSAD_RGN_PERIPH: ext_rdata_q <= i_periph_rdata;
            DSAD_RGN_DEBUG:  ext_rdata_q <= i_debug_rdata;
            default:         ext_rdata_q <= i_ext_rdata;
         endcase
      end
   end

   assign o_rvalid = rvalid_q;
   assign o_rdata  = !rvalid_q ? 32'h00000000 :
                     (region_q == DSAD_RGN_RAM) ? ram_rdata_q : ext_rdata_q;
endmodule : dsad_decode

`default_nettype wire

// ==== common/dsad_pkg.sv ====
// Constants and carrier types for the data-space address decoder
package dsad_pkg;
   // ----------------------------------------------------------------
   // Address geometry
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 24;
   localparam int          WORD_W        = 16;
   localparam int          LONG_W        = 32;
   localparam logic [23:0] RAM_LO        = 24'h000000;
   localparam logic [23:0] RAM_HI        = 24'h000FFF;
   localparam logic [23:0] DFLASH_LO     = 24'h001000;
   localparam logic [23:0] DFLASH_HI     = 24'h001FFF;
   localparam logic [23:0] PERIPH_LO     = 24'h00F000;
   localparam logic [23:0] PERIPH_HI     = 24'h00FFFF;
   localparam logic [23:0] DEBUG_LO      = 24'hFFFF00;
   localparam logic [23:0] DEBUG_HI      = 24'hFFFFFF;
   localparam int          RAM_DEPTH     = 2048;
   localparam int          RAM_AW        = 11;
   localparam int          PERIPH_AW     = 12;
   localparam int          DFLASH_AW     = 12;
   localparam int          DEBUG_AW      = 8;
   // ----------------------------------------------------------------
   // Flash configuration block at top of program flash
   // ----------------------------------------------------------------
   localparam logic [23:0] CFG_FIRST     = 24'h00FFF7;
   localparam logic [23:0] CFG_LAST      = 24'h00FFFF;
   localparam int          CFG_WORDS     = 9;
   localparam logic [3:0]  CFG_LAST_IDX  = 4'h8;

   typedef enum logic [2:0] {
      DSAD_RGN_RAM, DSAD_RGN_DFLASH, DSAD_RGN_PERIPH, DSAD_RGN_DEBUG, DSAD_RGN_EXT
   } dsad_region_t;

   // Core data bus request: word address, long-word flag, write data
   typedef struct packed {
      logic              valid;
      logic              write;
      logic              long_op;
      logic [23:0]       addr;
      logic [31:0]       wdata;
   } dsad_req_t;

   // Request forwarded to one off-block target
   typedef struct packed {
      logic              sel;
      logic              write;
      logic              long_op;
      logic [23:0]       addr;
      logic [31:0]       wdata;
   } dsad_tgt_t;
endpackage : dsad_pkg

// ==== tb/dsad_decode_sva.sv ====
// Port checker for the data-space decoder
`timescale 1ns/100ps
`default_nettype none
module dsad_decode_sva (
   input wire logic                i_sys_clk,
   input wire logic                i_rst,
   input wire logic                i_external_data_select,
   input wire dsad_pkg::dsad_req_t i_req,
   input wire logic                o_ready,
   input wire logic [31:0]         o_rdata,
   input wire logic                o_rvalid,
   input wire dsad_pkg::dsad_tgt_t o_dflash,
   input wire dsad_pkg::dsad_tgt_t o_periph,
   input wire dsad_pkg::dsad_tgt_t o_debug,
   input wire dsad_pkg::dsad_tgt_t o_ext,
   input wire logic [31:0]         i_periph_rdata,
   input wire logic                o_pflash_rd,
   input wire logic [23:0]         o_pflash_addr,
   input wire logic                o_cfg_we
);
   import dsad_pkg::*;
   logic tk;
   logic [3:0] sels;
   assign tk   = i_req.valid && o_ready;
   assign sels = {o_dflash.sel, o_periph.sel, o_debug.sel, o_ext.sel};
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   chk_periph_any_mode: assert property (tk && i_req.addr >= PERIPH_LO && i_req.addr <= PERIPH_HI |-> sels == 4'h4)
      else $error("peripheral window not selected");
   chk_debug_top: assert property (tk && i_req.addr >= DEBUG_LO |-> sels == 4'h2)
      else $error("debug window not selected");
   chk_one_target: assert property ($onehot0(sels))
      else $error("several targets selected");
   chk_read_answer: assert property (tk && !i_req.write |=> o_rvalid)
      else $error("read not answered next cycle");
   chk_write_silent: assert property (tk && i_req.write |=> !o_rvalid)
      else $error("write answered");
   chk_no_early_use: assert property (!o_ready |-> sels == 4'h0)
      else $error("target selected before config load");
   chk_cfg_follows: assert property (o_pflash_rd |-> ##1 o_cfg_we)
      else $error("config write missing after fetch");
   chk_cfg_window: assert property (o_pflash_rd |-> o_pflash_addr >= CFG_FIRST && o_pflash_addr <= CFG_LAST)
      else $error("config fetch outside top words");
   chk_low_ext_mode: assert property (tk && $past(i_external_data_select) && i_req.addr <= DFLASH_HI |-> o_ext.sel)
      else $error("low range not external in mode 1");
   chk_ram_local: assert property (tk && !$past(i_external_data_select) && i_req.addr <= RAM_HI |-> sels == 4'h0)
      else $error("RAM range left the block");
   chk_word_addr: assert property (o_ext.sel |-> o_ext.addr == i_req.addr)
      else $error("external address rescaled");
   chk_periph_data: assert property (o_periph.sel && !i_req.write |=> o_rdata == $past(i_periph_rdata))
      else $error("peripheral read data lost");
endmodule : dsad_decode_sva
bind dsad_decode dsad_decode_sva u_sva (
   .i_sys_clk              (i_sys_clk),
   .i_rst                  (i_rst),
   .i_external_data_select (i_external_data_select),
   .i_req                  (i_req),
   .o_ready                (o_ready),
   .o_rdata                (o_rdata),
   .o_rvalid               (o_rvalid),
   .o_dflash               (o_dflash),
   .o_periph               (o_periph),
   .o_debug                (o_debug),
   .o_ext                  (o_ext),
   .i_periph_rdata         (i_periph_rdata),
   .o_pflash_rd            (o_pflash_rd),
   .o_pflash_addr          (o_pflash_addr),
   .o_cfg_we               (o_cfg_we)
);
`default_nettype wire

// ==== tb/dsad_far_model.sv ====
// Program flash and zero-wait target model
`timescale 1ns/100ps
`default_nettype none
module dsad_far_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_pflash_rd,
   input  wire logic [23:0] i_pflash_addr,
   output logic [15:0]      o_pflash_rdata,
   output logic [31:0]      o_dflash_rdata,
   output logic [31:0]      o_periph_rdata,
   output logic [31:0]      o_debug_rdata,
   output logic [31:0]      o_ext_rdata
);
   logic [15:0] idle_q = 16'h0000;
   // Fixed contents survive any reset; a read is answered in its own cycle,
   // idle cycles toggle so stale data never passes
   always @(posedge i_sys_clk) idle_q <= ~idle_q;
   assign o_pflash_rdata = i_pflash_rd ? {4'hA, i_pflash_addr[11:0]} : idle_q;
   assign o_dflash_rdata = 32'hD0D0_0001;
   assign o_periph_rdata = 32'h5050_0002;
   assign o_debug_rdata  = 32'hDB00_0003;
   assign o_ext_rdata    = 32'hE0E0_0004;
endmodule : dsad_far_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the data-space decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
   import dsad_pkg::*;
   logic i_sys_clk = 0, i_rst = 1, mode = 0;
   dsad_req_t i_req = '0;
   dsad_tgt_t o_dflash, o_periph, o_debug, o_ext;
   logic [31:0] o_rdata, r_df, r_pe, r_db, r_ex;
   logic [23:0] pf_addr;
   logic [15:0] pf_data, cfg_data, cfg_seen[9];
   logic [3:0]  cfg_idx, idx_seen[9];
   logic o_ready, o_rvalid, pf_rd, cfg_we, init_done;
   int n_errors = 0, checked = 0, cyc = 0, ncfg = 0;
   logic [23:0] ta[12] = '{24'h000000, 24'h000FFF, 24'h001000, 24'h001FFF, 24'h002000, 24'h00EFFF,
                           24'h00F000, 24'h00FFFF, 24'h010000, 24'hFFFEFF, 24'hFFFF00, 24'hFFFFFF};
   logic [3:0] ts[12] = '{4'h0, 4'h0, 4'h8, 4'h8, 4'h1, 4'h1, 4'h4, 4'h4, 4'h1, 4'h1, 4'h2, 4'h2};
   always #2.5 i_sys_clk = ~i_sys_clk;
   dsad_decode uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_external_data_select(mode), .i_req(i_req),
      .o_ready(o_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_dflash(o_dflash), .o_periph(o_periph),
      .o_debug(o_debug), .o_ext(o_ext), .i_dflash_rdata(r_df), .i_periph_rdata(r_pe), .i_debug_rdata(r_db),
      .i_ext_rdata(r_ex), .o_pflash_rd(pf_rd), .o_pflash_addr(pf_addr), .i_pflash_rdata(pf_data),
      .o_cfg_we(cfg_we), .o_cfg_idx(cfg_idx), .o_cfg_data(cfg_data), .o_init_done(init_done));
   dsad_far_model far (.i_sys_clk(i_sys_clk), .i_pflash_rd(pf_rd), .i_pflash_addr(pf_addr),
      .o_pflash_rdata(pf_data), .o_dflash_rdata(r_df), .o_periph_rdata(r_pe), .o_debug_rdata(r_db),
      .o_ext_rdata(r_ex));
   always @(negedge i_sys_clk) begin
      if (cfg_we === 1'b1 && ncfg < 9) begin
         idx_seen[ncfg] = cfg_idx;
         cfg_seen[ncfg] = cfg_data;
         ncfg++;
      end
   end
   // Hang guard well above the fewer than 100 cycles the run needs
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   task automatic print_verdict();
      if (n_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   // Entered at a falling edge; leaves the request up for the caller
   task automatic acc(input logic w, l, input logic [23:0] a, input logic [31:0] wd, m, er, input logic [3:0] es);
      i_req = '{1'b1, w, l, a, wd};
      #1;
      check({o_dflash.sel, o_periph.sel, o_debug.sel, o_ext.sel}, es);
      check(o_dflash.addr, a);
      @(negedge i_sys_clk);
      check(o_rvalid, !w);
      if (!w) check(o_rdata & m, er);
   endtask : acc
   task automatic t_init();
      i_req = '{1'b1, 1'b0, 1'b0, 24'h00F000, 32'h0};
      #1;
      check(o_periph.sel, 0);
      for (int i = 0; i < 100 && init_done !== 1'b1; i++) @(negedge i_sys_clk);
      i_req.valid = 0;
      check(ncfg, 9);
      check(o_ready, 1);
      for (int i = 0; i < 9; i++) check({idx_seen[i], cfg_seen[i]}, {4'(i), 16'hAFF7 + 16'(i)});
   endtask : t_init
   task automatic t_map(input logic md);
      logic [3:0] es;
      mode = md;
      repeat (2) @(negedge i_sys_clk);
      for (int i = 0; i < 12; i++) begin
         es = (md && (ts[i] == 0 || ts[i] == 8)) ? 4'h1 : ts[i];
         acc(0, 0, ta[i], 0, es ? 32'hFFFF_FFFF : 0, es[3] ? r_df : es[2] ? r_pe : es[1] ? r_db : es[0] ? r_ex : 0, es);
      end
      i_req.valid = 0;
   endtask : t_map
   task automatic t_ram();
      acc(1, 1, 24'h000FFE, 32'hCAFE_1234, 0, 0, 0);
      acc(1, 1, 24'h000002, 32'h8765_4321, 0, 0, 0);
      acc(0, 1, 24'h000FFE, 0, 32'hFFFF_FFFF, 32'hCAFE_1234, 0);
      acc(0, 0, 24'h000FFF, 0, 32'h0000_FFFF, 32'h0000_CAFE, 0);
      acc(1, 0, 24'h000003, 32'h0000_55AA, 0, 0, 0);
      acc(0, 1, 24'h000002, 0, 32'hFFFF_FFFF, 32'h55AA_4321, 0);
      i_req.valid = 0;
   endtask : t_ram
   // Mid-run reset: the configuration words must be fetched again
   task automatic t_reset();
      i_rst = 1;
      ncfg  = 0;
      repeat (3) @(negedge i_sys_clk);
      check(o_ready, 0);
      i_rst = 0;
      t_init();
   endtask : t_reset
   initial begin
      repeat (10) @(negedge i_sys_clk);
      i_rst = 0;
      t_init();
      t_map(0);
      t_ram();
      t_map(1);
      t_reset();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
